//--- stc_clk_src.sv
/* far side model: watch crystal and external count clock
   assumes the core clock as time base and the oscillator run flag */
`timescale 1ns/1ps
`default_nettype none
module stc_clk_src (
  // time base and requests
  input wire logic clock,
  input wire logic xtal_en,
  input wire logic go,
  input wire logic [3:0] edges,
  // pin levels
  output logic xtal,
  output logic ext
);
  // ====================
  // generators
  logic [3:0] left = 4'h0;
  logic [2:0] ph = 3'h0;
  logic [2:0] xc = 3'h0;
  initial xtal = 1'b0;
  initial ext = 1'b0;
  // crystal swings only while enabled, rests low when off
  always @(posedge clock) begin
    xc <= xc + 3'h1;
    if (xc == 3'h7)
      xtal <= xtal_en & ~xtal;
  end
  // burst of rising edges, three clocks high then three low
  always @(posedge clock) begin
    if (go) begin
      left <= edges;
      ph <= 3'h0;
    end else if (left != 4'h0) begin
      ph <= (ph == 3'h5) ? 3'h0 : ph + 3'h1;
      if (ph == 3'h5)
        left <= left - 4'h1;
    end
    ext <= (left != 4'h0) && (ph < 3'h3);
  end
endmodule // stc_clk_src
`default_nettype wire

//--- stc_map.vh
/*
  Register map, field positions, reset values and timing counts of the
  sixteen bit timer/counter.
  Assumes a 32-bit AHB-Lite slave and a 200 MHz core clock.
*/
// Functional notes
// [R1] three modes: internal timer, synchronous counter, asynchronous counter
// [R2] source select zero: count once per instruction cycle, clock divided by four
// [R3] source select one: count rising edges of external pin or crystal output
// [R4] timer enabled: both pins forced to inputs, port reads of them return zero
// [R5] wide mode: high address selects buffer; low read copies live high
// [R6] wide mode: low write loads live high from buffer at same time
// [R7] wide mode: live high byte never accessed directly, only via buffer
// [R8] low write clears prescaler; high write does not
// [R9] crystal oscillator runs only while its enable bit is set
// [R10] enabled crystal oscillator keeps running in sleep and idle modes
// [R11] software waits a start-up delay after enabling the crystal
// [R12] clock select 01 clocks cpu and peripherals from the crystal
// [R13] idle enable clear plus sleep while on crystal enters secondary idle
// [R14] read-only status bit set while crystal supplies device clock
// [R15] after fail-safe switch away, status bit shows the other source
// [R16] count pair counts 0000h to ffffh then wraps to 0000h
// [R17] each wrap sets overflow flag, held until software clears it
// [R18] overflow interrupt passes only while its enable bit is set
// [R19] compare mode 1011 special event trigger resets count, acts as period
// [R20] event reset guaranteed only in timer or synchronous counter mode
// [R21] software count write in same cycle as event reset wins
// [R22] event reset never sets the overflow flag
// [R23] counts only while timer enable bit set, holds when clear
// [R24] synchronous mode: edges via two-stage synchroniser; asynchronous: direct
`ifndef STC_MAP_VH
`define STC_MAP_VH

// ==========================================================
// register byte offsets
`define STC_CTRL_OFF 8'h00
`define STC_CNTL_OFF 8'h04
`define STC_CNTH_OFF 8'h08
`define STC_FLAG_OFF 8'h0c
`define STC_IEN_OFF 8'h10
`define STC_OSC_OFF 8'h14
`define STC_PORT_OFF 8'h18

// ==========================================================
// control register fields
`define STC_CTRL_ON 0
`define STC_CTRL_CS 1
`define STC_CTRL_NOSYNC 2
`define STC_CTRL_OSCEN 3
`define STC_CTRL_PS_LO 4
`define STC_CTRL_PS_HI 5
`define STC_CTRL_RUN 6
`define STC_CTRL_WIDE 7
`define STC_CTRL_RST 8'h00

// ==========================================================
// oscillator control fields
`define STC_OSC_SCS_LO 0
`define STC_OSC_SCS_HI 1
`define STC_OSC_IDLE_ENABLE_BIT 7
`define STC_OSC_RST 8'h00
`define STC_SCS_CRYSTAL 2'h1

// ==========================================================
// port register fields and reset
`define STC_PORT_DIR_LO 0
`define STC_PORT_PIN_LO 2
`define STC_PORT_LAT_LO 4
`define STC_PORT_RST 8'h03

// ==========================================================
// compare unit, timing
`define STC_CMP_RESET_CODE 4'hb
`define STC_INSTR_DIV 2'h3
`endif

//--- stc_timer.v
/*
  Sixteen bit timer/counter with byte access, wide access buffer,
  prescaler, overflow flag, crystal clock status and power-mode state.
  Assumes one 200 MHz clock, synchronous pin inputs and an AHB-Lite
  master that issues single word transfers only.
*/
// Added by the designer: the placing of the registers and the AHB-Lite register port.
`timescale 1ns/1ps
`default_nettype none
`include "stc_map.vh"

module stc_timer (
  // clock and reset
  input wire clock,
  input wire rstn,
  // ahb-lite slave
  input wire hsel,
  input wire [7:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg hreadyout,
  output reg hresp,
  output reg [31:0] hrdata,
  // crystal input pin, also crystal oscillator output level
  input wire crystal_in_pin_i,
  output reg crystal_in_pin_o,
  output reg crystal_in_pin_oe,
  // external count clock pin
  input wire external_count_clock_pin_i,
  output reg external_count_clock_pin_o,
  output reg external_count_clock_pin_oe,
  // compare unit, clock monitor and power-mode requests
  input wire special_event_trigger,
  input wire [3:0] compare_mode_code,
  input wire crystal_failed,
  input wire sleep_request,
  input wire wake_event,
  // status outputs
  output reg overflow_irq,
  output reg crystal_osc_run,
  output reg sysclk_from_crystal,
  output reg [2:0] power_mode
);

  // power-mode states, one-hot
  localparam [2:0] PM_RUN = 3'h1;
  localparam [2:0] PM_SEC_RUN = 3'h2;
  localparam [2:0] PM_SEC_IDLE = 3'h4;

  // ==========================================================
  // register decode

  // address match, used by both read and write paths
  function is_reg;
    input [7:0] a;
    input [7:0] off;
    begin
      is_reg = (a[7:2] == off[7:2]);
    end
  endfunction

  reg [7:0] ctrl_q;
  reg [7:0] osc_q;
  reg [7:0] port_q;
  reg [15:0] count_q;
  reg [7:0] hibuf_q;
  reg flag_q;
  reg ien_q;
  reg [7:0] wr_addr_q;
  reg wr_pend_q;
  reg [7:0] rd_addr_q;
  reg rd_pend_q;
  reg [1:0] div_q;
  reg [2:0] pre_q;
  reg sync1_q;
  reg sync2_q;
  reg sync3_q;
  reg async_q;
  reg async_prev_q;
  reg [2:0] pm_q;

  wire timer_on = ctrl_q[`STC_CTRL_ON];
  wire wide = ctrl_q[`STC_CTRL_WIDE];
  wire ext_src = ctrl_q[`STC_CTRL_CS];
  wire no_sync = ctrl_q[`STC_CTRL_NOSYNC];
  wire osc_en = ctrl_q[`STC_CTRL_OSCEN];
  wire [1:0] ps_sel = ctrl_q[`STC_CTRL_PS_HI:`STC_CTRL_PS_LO];
  wire [1:0] scs = osc_q[`STC_OSC_SCS_HI:`STC_OSC_SCS_LO];

  // address phase sampled on a ready bus
  wire take = hsel & hready & htrans[1];
  wire wr_now = wr_pend_q;
  wire wr_ctrl = wr_now & is_reg(wr_addr_q, `STC_CTRL_OFF);
  wire wr_cntl = wr_now & is_reg(wr_addr_q, `STC_CNTL_OFF);
  wire wr_cnth = wr_now & is_reg(wr_addr_q, `STC_CNTH_OFF);
  wire wr_flag = wr_now & is_reg(wr_addr_q, `STC_FLAG_OFF);
  wire wr_ien = wr_now & is_reg(wr_addr_q, `STC_IEN_OFF);
  wire wr_osc = wr_now & is_reg(wr_addr_q, `STC_OSC_OFF);
  wire wr_port = wr_now & is_reg(wr_addr_q, `STC_PORT_OFF);
  wire rd_cntl = rd_pend_q & is_reg(rd_addr_q, `STC_CNTL_OFF);
  wire [7:0] wbyte = hwdata[7:0];

  // ==========================================================
  // bus handshake: writes take no wait, reads take one wait state
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      wr_pend_q <= 1'b0;
      rd_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
      rd_addr_q <= 8'h00;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      wr_pend_q <= take & hwrite;
      if (take)
        wr_addr_q <= haddr;
      if (take & ~hwrite) begin
        rd_pend_q <= 1'b1;
        rd_addr_q <= haddr;
        hreadyout <= 1'b0;
      end else begin
        rd_pend_q <= 1'b0;
        hreadyout <= 1'b1;
      end
    end
  end

  // ==========================================================
  // read data, captured in the wait cycle so prior writes are seen
  wire [7:0] pin_view = timer_on ? 8'h00 :
    {6'h00, external_count_clock_pin_i, crystal_in_pin_i};

  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      hrdata <= 32'h00000000;
    end else if (rd_pend_q) begin
      if (is_reg(rd_addr_q, `STC_CTRL_OFF))
        hrdata <= {24'h000000, ctrl_q};
      else if (is_reg(rd_addr_q, `STC_CNTL_OFF))
        hrdata <= {24'h000000, count_q[7:0]};
      else if (is_reg(rd_addr_q, `STC_CNTH_OFF))
        hrdata <= {24'h000000, wide ? hibuf_q : count_q[15:8]}; // see [R7]
      else if (is_reg(rd_addr_q, `STC_FLAG_OFF))
        hrdata <= {31'h00000000, flag_q};
      else if (is_reg(rd_addr_q, `STC_IEN_OFF))
        hrdata <= {31'h00000000, ien_q};
      else if (is_reg(rd_addr_q, `STC_OSC_OFF))
        hrdata <= {24'h000000, osc_q};
      else if (is_reg(rd_addr_q, `STC_PORT_OFF))
        // pins read as zero while the timer owns them
        hrdata <= {24'h000000, port_q[7:4],
          pin_view[1:0], port_q[1:0]}; // see [R4]
      else
        hrdata <= 32'h00000000;
    end
  end

  // ==========================================================
  // control, oscillator, port and enable registers
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      ctrl_q <= `STC_CTRL_RST;
      osc_q <= `STC_OSC_RST;
      port_q <= `STC_PORT_RST;
      ien_q <= 1'b0;
    end else begin
      if (wr_ctrl)
        ctrl_q <= {wbyte[7], sysclk_from_crystal, wbyte[5:0]};
      else
        ctrl_q[`STC_CTRL_RUN] <= sysclk_from_crystal; // see [R14]
      if (wr_osc)
        osc_q <= {wbyte[7], 5'h00, wbyte[1:0]};
      if (wr_port)
        port_q <= {2'h0, wbyte[5:4], 2'h0, wbyte[1:0]};
      if (wr_ien)
        ien_q <= wbyte[0];
    end
  end

  // ==========================================================
  // pin drivers: timer enable forces both pins to inputs
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      crystal_in_pin_o <= 1'b0;
      crystal_in_pin_oe <= 1'b0;
      external_count_clock_pin_o <= 1'b0;
      external_count_clock_pin_oe <= 1'b0;
    end else begin
      crystal_in_pin_o <= port_q[`STC_PORT_LAT_LO];
      external_count_clock_pin_o <= port_q[`STC_PORT_LAT_LO+1];
      crystal_in_pin_oe <= ~port_q[`STC_PORT_DIR_LO] & ~timer_on; // see [R4]
      external_count_clock_pin_oe <=
        ~port_q[`STC_PORT_DIR_LO+1] & ~timer_on; // see [R4]
    end
  end

  // ==========================================================
  // crystal oscillator, clock status and power modes
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      crystal_osc_run <= 1'b0;
      sysclk_from_crystal <= 1'b0;
      pm_q <= PM_RUN;
      power_mode <= PM_RUN;
    end else begin
      // oscillator follows its enable only, whatever the power mode
      crystal_osc_run <= osc_en; // see [R9] [R10]
      // fail-safe monitor takes the clock away from a dead crystal
      sysclk_from_crystal <= (scs == `STC_SCS_CRYSTAL) & osc_en &
        ~crystal_failed; // see [R12] [R14] [R15]
      power_mode <= pm_q;
      case (pm_q)
        PM_RUN: begin
          if ((scs == `STC_SCS_CRYSTAL) & osc_en & ~crystal_failed)
            pm_q <= PM_SEC_RUN; // see [R12]
        end
        PM_SEC_RUN: begin
          if (crystal_failed | (scs != `STC_SCS_CRYSTAL) | ~osc_en)
            pm_q <= PM_RUN; // see [R15]
          else if (sleep_request & ~osc_q[`STC_OSC_IDLE_ENABLE_BIT])
            pm_q <= PM_SEC_IDLE; // see [R13]
        end
        PM_SEC_IDLE: begin
          if (crystal_failed | ~osc_en)
            pm_q <= PM_RUN;
          else if (wake_event)
            pm_q <= PM_SEC_RUN;
        end
        default: begin
          pm_q <= PM_RUN;
        end
      endcase
    end
  end

  // ==========================================================
  // count sources: instruction divider and external edge paths
  wire ext_level = osc_en ? crystal_in_pin_i : external_count_clock_pin_i;
  wire sync_edge = sync2_q & ~sync3_q;
  wire async_edge = async_q & ~async_prev_q;
  wire instr_tick = (div_q == `STC_INSTR_DIV);
  wire src_tick = ext_src ? (no_sync ? async_edge : sync_edge)
    : instr_tick; // see [R1] [R2] [R3]

  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      div_q <= 2'h0;
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      sync3_q <= 1'b0;
      async_q <= 1'b0;
      async_prev_q <= 1'b0;
    end else begin
      div_q <= div_q + 2'h1; // see [R2]
      // two-stage synchroniser, then edge detector
      sync1_q <= ext_level; // see [R24]
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
      // direct path, one register, then edge detector
      async_q <= ext_level; // see [R24]
      async_prev_q <= async_q;
    end
  end

  // ==========================================================
  // prescaler 1:1, 1:2, 1:4, 1:8
  wire [2:0] pre_max = (ps_sel == 2'h0) ? 3'h0 : (ps_sel == 2'h1) ? 3'h1 :
    (ps_sel == 2'h2) ? 3'h3 : 3'h7;
  wire count_tick = timer_on & src_tick & (pre_q == pre_max); // see [R23]

  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      pre_q <= 3'h0;
    end else if (wr_cntl) begin
      pre_q <= 3'h0; // see [R8]
    end else if (timer_on & src_tick) begin
      pre_q <= (pre_q == pre_max) ? 3'h0 : pre_q + 3'h1;
    end
  end

  // ==========================================================
  // count pair, high buffer, overflow flag and interrupt
  wire evt_reset = special_event_trigger &
    (compare_mode_code == `STC_CMP_RESET_CODE) &
    ~(ext_src & no_sync); // see [R19] [R20]
  wire wrap = count_tick & (count_q == 16'hffff);

  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      count_q <= 16'h0000;
      hibuf_q <= 8'h00;
      flag_q <= 1'b0;
      overflow_irq <= 1'b0;
    end else begin
      // low read snapshots the live high byte
      if (rd_cntl & wide)
        hibuf_q <= count_q[15:8]; // see [R5]
      else if (wr_cnth & wide)
        hibuf_q <= wbyte; // see [R5] [R7]
      // software write first, then event reset, then counting
      if (wr_cntl) begin
        if (wide)
          count_q <= {hibuf_q, wbyte}; // see [R6] [R21]
        else
          count_q[7:0] <= wbyte; // see [R21]
      end else if (wr_cnth & ~wide) begin
        count_q[15:8] <= wbyte;
      end else if (evt_reset) begin
        count_q <= 16'h0000; // see [R19] [R22]
      end else if (count_tick) begin
        count_q <= count_q + 16'h0001; // see [R16] [R23]
      end
      // wrap sets the flag and beats a clear in the same cycle
      if (wrap & ~wr_cntl & ~(wr_cnth & ~wide) & ~evt_reset)
        flag_q <= 1'b1; // see [R17]
      else if (wr_flag)
        flag_q <= wbyte[0];
      overflow_irq <= flag_q & ien_q; // see [R18]
    end
  end

endmodule // stc_timer
`default_nettype wire

//--- stc_timer_properties.sv
/* checker for the timer status and pin ports
   assumes a bind onto stc_timer with hready fed from hreadyout */
`timescale 1ns/1ps
`default_nettype none
`include "stc_map.vh"
module stc_timer_props (
  // clock, reset, bus
  input wire logic clock,
  input wire logic rstn,
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  // pins and status
  input wire logic crystal_in_pin_oe,
  input wire logic external_count_clock_pin_oe,
  input wire logic crystal_failed,
  input wire logic overflow_irq,
  input wire logic crystal_osc_run,
  input wire logic sysclk_from_crystal,
  input wire logic [2:0] power_mode
);
  // ====================
  // shadow of written control state
  logic w_q;
  logic ien_q;
  logic [7:0] a_q, ctl_q, osc_q;
  // capture write address phase, commit at its data phase
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      {w_q, ien_q} <= 2'h0;
      {a_q, ctl_q, osc_q} <= 24'h0;
    end else if (hready) begin
      w_q <= hsel && htrans[1] && hwrite;
      a_q <= haddr;
      if (w_q && a_q == `STC_CTRL_OFF)
        ctl_q <= hwdata[7:0];
      if (w_q && a_q == `STC_IEN_OFF)
        ien_q <= hwdata[0];
      if (w_q && a_q == `STC_OSC_OFF)
        osc_q <= hwdata[7:0];
    end
  end

  // ====================
  // properties
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);
  pins_input_a: assert property (
    ctl_q[0] && $past(ctl_q[0]) |-> !crystal_in_pin_oe
      && !external_count_clock_pin_oe) else $error("pin driven");
  osc_run_a: assert property (
    crystal_osc_run == $past(ctl_q[3])) else $error("osc run");
  osc_keep_a: assert property (
    $past(ctl_q[3]) && power_mode != 3'h1 |-> crystal_osc_run)
    else $error("osc stopped");
  power_src_a: assert property (
    power_mode != 3'h1 |-> $past(sysclk_from_crystal))
    else $error("power mode");
  idle_entry_a: assert property (
    $rose(power_mode[2]) |-> $past(power_mode) == 3'h2
      && !$past(osc_q[7])) else $error("idle entry");
  clk_status_a: assert property (
    sysclk_from_crystal |-> $past(ctl_q[3]
      && osc_q[1:0] == `STC_SCS_CRYSTAL)) else $error("status");
  fail_switch_a: assert property (
    crystal_failed |=> !sysclk_from_crystal) else $error("fail");
  irq_gate_a: assert property (
    overflow_irq |-> $past(ien_q)) else $error("irq gate");
endmodule // stc_timer_props

bind stc_timer stc_timer_props u_props (.clock(clock), .rstn(rstn),
  .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
  .hwdata(hwdata), .hready(hready), .crystal_failed(crystal_failed),
  .crystal_in_pin_oe(crystal_in_pin_oe), .power_mode(power_mode),
  .external_count_clock_pin_oe(external_count_clock_pin_oe),
  .overflow_irq(overflow_irq), .crystal_osc_run(crystal_osc_run),
  .sysclk_from_crystal(sysclk_from_crystal));
`default_nettype wire

//--- stc_timer_tb_top.sv
/* self-checking bench for the sixteen bit timer/counter
   assumes stc_timer, the clock source model and the checker bind */
`timescale 1ns/1ps
`default_nettype none
`include "stc_map.vh"
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin fails++; \
  $display("[FAIL] %s expected %h seen %h", n, e, g); end end
module stc_timer_tb_top;
  // ====================
  // stimulus, wiring and counters
  localparam logic [7:0] CTL = `STC_CTRL_OFF, LO = `STC_CNTL_OFF;
  localparam logic [7:0] HI = `STC_CNTH_OFF, FLG = `STC_FLAG_OFF;
  localparam logic [7:0] IEN = `STC_IEN_OFF, OSC = `STC_OSC_OFF;
  logic clock = 1'b0, rstn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic go = 1'b0, trig = 1'b0, bad = 1'b0, slp = 1'b0, wake = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [3:0] code = 4'h0, nedge = 4'h0;
  logic [7:0] haddr = 8'h0, rd, cnt;
  logic [31:0] hwdata = 32'h0;
  integer fails = 0, checks = 0;
  wire hrdy, xo, xoe, eo, eoe, xtal, ext, xrun, sysclk, irq, resp;
  wire [31:0] hrdata;
  wire [2:0] pmode;
  // pin levels: the design wins while it drives
  wire xpin = xoe ? xo : xtal;
  wire epin = eoe ? eo : ext;
  initial forever #2.5 clock = ~clock;
  stc_timer uut (.clock(clock), .rstn(rstn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hrdy), .hreadyout(hrdy), .hresp(resp), .hrdata(hrdata),
    .crystal_in_pin_i(xpin), .crystal_in_pin_o(xo),
    .crystal_in_pin_oe(xoe), .external_count_clock_pin_i(epin),
    .external_count_clock_pin_o(eo), .external_count_clock_pin_oe(eoe),
    .special_event_trigger(trig), .compare_mode_code(code),
    .crystal_failed(bad), .sleep_request(slp), .wake_event(wake),
    .overflow_irq(irq), .crystal_osc_run(xrun),
    .sysclk_from_crystal(sysclk), .power_mode(pmode));
  stc_clk_src src (.clock(clock), .xtal_en(xrun), .go(go),
    .edges(nedge), .xtal(xtal), .ext(ext));

  // ====================
  // shared tasks
  task tick(input integer k);
    repeat (k) @(posedge clock);
  endtask
  task results;
    begin
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0)
        $display("Testbench passed");
      else
        $display("Testbench failed");
      $finish;
    end
  endtask
  // one single transfer, entered just after a rising edge
  task bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    integer n;
    begin
      n = 0;
      hsel <= 1'b1;
      hwrite <= w;
      haddr <= a;
      htrans <= 2'h2;
      @(posedge clock);
      while (!hrdy && n < 50) begin
        n++;
        @(posedge clock);
      end
      htrans <= 2'h0;
      hwdata <= {24'h0, d};
      @(posedge clock);
      while (!hrdy && n < 50) begin
        n++;
        @(posedge clock);
      end
      rd = hrdata[7:0];
      if (n >= 50) begin
        fails++;
        results;
      end
    end
  endtask
  task rchk(input logic [7:0] a, input logic [7:0] e, input string s);
    begin
      bus(1'b0, a, 8'h00);
      `CHK(s, e, rd)
    end
  endtask
  task ev(input logic [3:0] c);
    begin
      code <= c;
      trig <= 1'b1;
      tick(1);
      trig <= 1'b0;
      tick(2);
    end
  endtask
  task edges(input logic [3:0] k);
    begin
      nedge <= k;
      go <= 1'b1;
      tick(1);
      go <= 1'b0;
      tick(6 * k + 8);
    end
  endtask

  // ====================
  // scenarios
  task t_reset;
    begin
      rchk(CTL, 8'h00, "ctrl");
      rchk(`STC_PORT_OFF, 8'h03, "port");
      // drive both pins high, then let the timer take them
      bus(1'b1, `STC_PORT_OFF, 8'h30);
      rchk(`STC_PORT_OFF, 8'h3c, "pins driven");
      bus(1'b1, CTL, 8'h01);
      rchk(`STC_PORT_OFF, 8'h30, "pins owned");
      `CHK("pin oe", 1'b0, xoe | eoe)
      bus(1'b1, CTL, 8'h00);
      bus(1'b1, `STC_PORT_OFF, 8'h03);
      bus(1'b1, 8'h1c, 8'hff);
      rchk(8'h1c, 8'h00, "unmapped");
    end
  endtask
  task t_wide;
    begin
      bus(1'b1, CTL, 8'h80);
      bus(1'b1, HI, 8'h12);
      bus(1'b1, LO, 8'h34);
      bus(1'b1, HI, 8'h56);
      rchk(LO, 8'h34, "wide low");
      rchk(HI, 8'h12, "wide copy");
      bus(1'b1, HI, 8'h56);
      rchk(HI, 8'h56, "wide buffer");
      `CHK("okay", 1'b0, resp)
      bus(1'b1, CTL, 8'h00);
      rchk(HI, 8'h12, "live high");
    end
  endtask
  task t_timer;
    begin
      bus(1'b1, HI, 8'hff);
      bus(1'b1, LO, 8'hfd);
      bus(1'b1, IEN, 8'h01);
      bus(1'b1, CTL, 8'h01);
      tick(26);
      bus(1'b1, CTL, 8'h00);
      bus(1'b0, LO, 8'h00);
      cnt = rd;
      // 28 enabled edges at one count per 4 clocks from fffd
      `CHK("ticks", 8'h04, cnt)
      rchk(HI, 8'h00, "wrap");
      rchk(FLG, 8'h01, "flag");
      `CHK("irq on", 1'b1, irq)
      tick(20);
      rchk(LO, cnt, "hold");
      bus(1'b1, IEN, 8'h00);
      tick(2);
      `CHK("irq off", 1'b0, irq)
      rchk(FLG, 8'h01, "flag held");
      bus(1'b1, FLG, 8'h00);
      rchk(FLG, 8'h00, "flag clear");
    end
  endtask
  task t_event;
    begin
      bus(1'b1, HI, 8'h12);
      bus(1'b1, LO, 8'h34);
      ev(4'ha);
      rchk(LO, 8'h34, "other code");
      bus(1'b1, CTL, 8'h06);
      ev(4'hb);
      rchk(LO, 8'h34, "async event");
      bus(1'b1, CTL, 8'h00);
      // reset from ffff must still leave the flag alone
      bus(1'b1, HI, 8'hff);
      bus(1'b1, LO, 8'hff);
      ev(4'hb);
      rchk(LO, 8'h00, "event low");
      rchk(HI, 8'h00, "event high");
      rchk(FLG, 8'h00, "event flag");
      // trigger lands on the edge that commits a low write
      code <= 4'hb;
      fork
        bus(1'b1, LO, 8'h77);
        begin
          tick(1);
          trig <= 1'b1;
          tick(1);
          trig <= 1'b0;
        end
      join
      rchk(LO, 8'h77, "write wins");
    end
  endtask
  task t_ext;
    begin
      bus(1'b1, CTL, 8'h03);
      bus(1'b1, LO, 8'h00);
      edges(4'h5);
      rchk(LO, 8'h05, "sync edges");
      bus(1'b1, CTL, 8'h07);
      bus(1'b1, LO, 8'h00);
      edges(4'h3);
      rchk(LO, 8'h03, "async edges");
      bus(1'b1, CTL, 8'h13);
      bus(1'b1, LO, 8'h00);
      edges(4'h1);
      bus(1'b1, HI, 8'h00);
      edges(4'h1);
      rchk(LO, 8'h01, "high write");
      bus(1'b1, LO, 8'h00);
      edges(4'h1);
      bus(1'b1, LO, 8'h00);
      edges(4'h1);
      rchk(LO, 8'h00, "low write");
      bus(1'b1, CTL, 8'h00);
    end
  endtask
  task t_osc;
    begin
      bus(1'b1, OSC, 8'h01);
      bus(1'b1, CTL, 8'h08);
      tick(4);
      `CHK("osc run", 1'b1, xrun)
      `CHK("sec run", 3'h2, pmode)
      rchk(CTL, 8'h48, "status");
      bad <= 1'b1;
      tick(4);
      `CHK("fail mode", 3'h1, pmode)
      rchk(CTL, 8'h08, "fail status");
      bad <= 1'b0;
      tick(4);
      slp <= 1'b1;
      tick(1);
      slp <= 1'b0;
      tick(4);
      `CHK("sec idle", 3'h4, pmode)
      `CHK("idle osc", 1'b1, xrun)
      wake <= 1'b1;
      tick(1);
      wake <= 1'b0;
      tick(4);
      `CHK("wake", 3'h2, pmode)
      bus(1'b1, CTL, 8'h00);
      tick(4);
      `CHK("osc off", 1'b0, xrun)
    end
  endtask

  // ====================
  // main sequence
  initial begin
    tick(2);
    rstn <= 1'b1;
    tick(1);
    t_reset;
    t_wide;
    t_timer;
    t_event;
    t_ext;
    t_osc;
    results;
  end
endmodule // stc_timer_tb_top
`default_nettype wire
